// ### design/macro_store.v
`timescale 1ns/1ps

module macro_store
(
	// Clock
	input  wire        clk_i,
	// Write port
	input  wire        wr_en_i,
	input  wire [10:0] wr_addr_i,
	input  wire [7:0]  wr_data_i,
	// Read port, one cycle latency
	input  wire [10:0] rd_addr_i,
	output reg  [7:0]  rd_data_o
);

	reg [7:0] mem [0:2047];

	// Contents carry no reset; validity is tracked by the stored length.
	always @(posedge clk_i)
	begin
		if (wr_en_i)
			mem[wr_addr_i] <= wr_data_i;
		rd_data_o <= mem[rd_addr_i];
	end

endmodule // macro_store

// ### design/printer_cmd_map.vh
`ifndef PRINTER_CMD_MAP_VH
`define PRINTER_CMD_MAP_VH

// ---------------------------------------------------------------------------
// Command bytes
// ---------------------------------------------------------------------------
`define BYTE_ESC            8'h1B
`define BYTE_GS             8'h1D
`define CMD_PRINT_IMAGE     8'h2F
`define CMD_MACRO_TOGGLE    8'h3A
`define CMD_MACRO_RUN       8'h5E
`define CMD_INPUT_SELECT    8'h3D
`define CMD_LINE_ALIGN      8'h61
`define CMD_FULL_CUT        8'h69
`define CMD_PARTIAL_CUT     8'h6D
`define CMD_PRINTER_INIT    8'h40
`define IMAGE_MODE_MAX      8'h03
`define RUN_MODE_FEED       8'h01

// ---------------------------------------------------------------------------
// Densities, line and macro sizes, timing
// ---------------------------------------------------------------------------
`define DPI_V_FULL          8'h9C
`define DPI_H_FULL          8'h9A
`define LINE_DOTS           11'h240
`define MACRO_BYTES         12'h800
`define DELAY_UNIT_MS       100
`define CLK_KHZ             10000
`define BLINK_CYCLES        24'h07A120

// ---------------------------------------------------------------------------
// AHB register map and fields
// ---------------------------------------------------------------------------
`define REG_IMAGE_CTRL      8'h00
`define REG_STATUS          8'h04
`define REG_STATUS_CLR      8'h08
`define F_IMAGE_DEF         0
`define F_CHARSET_DEF       1
`define F_WIDTH_LO          8
`define F_WIDTH_HI          15
`define F_SELECTED          0
`define F_RECORDING         1
`define F_RUNNING           2
`define F_ABORT             3
`define F_ALIGN_LO          4
`define F_ALIGN_HI          5
`define F_LEN_LO            16
`define F_LEN_HI            27
`define HTRANS_NONSEQ_BIT   1

`endif

// ### design/printer_command_decoder.v
// Chosen here: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "printer_cmd_map.vh"

module printer_command_decoder
#(
	parameter DELAY_UNIT_CYCLES = (`DELAY_UNIT_MS * `CLK_KHZ)
)
(
	// Clock and reset
	input  wire        clk_i,
	input  wire        reset_n_i,
	// AHB-Lite slave
	input  wire        hsel_i,
	input  wire [31:0] haddr_i,
	input  wire [1:0]  htrans_i,
	input  wire        hwrite_i,
	input  wire [2:0]  hsize_i,
	input  wire [31:0] hwdata_i,
	input  wire        hready_i,
	output reg  [31:0] hrdata_o,
	output wire        hreadyout_o,
	output wire        hresp_o,
	// Host byte stream
	input  wire [7:0]  rx_data_i,
	input  wire        rx_valid_i,
	output wire        rx_ready_o,
	output wire        busy_o,
	// Print engine
	input  wire        line_start_i,
	input  wire        print_buf_empty_i,
	input  wire        print_busy_i,
	output reg  [7:0]  print_data_o,
	output reg         print_valid_o,
	output reg         image_print_o,
	output reg  [1:0]  image_mode_o,
	output reg  [7:0]  image_vdpi_o,
	output reg  [7:0]  image_hdpi_o,
	output reg  [10:0] image_dots_o,
	output reg  [1:0]  line_align_o,
	output reg         full_cut_o,
	output reg         partial_cut_o,
	output reg         printer_init_o,
	output reg         macro_abort_o,
	// Operator panel
	input  wire        feed_switch_i,
	output wire        feed_advance_o,
	output reg         error_lamp_o
);

	localparam [3:0] P_IDLE  = 4'b0001;
	localparam [3:0] P_ESC   = 4'b0010;
	localparam [3:0] P_GS    = 4'b0100;
	localparam [3:0] P_PARAM = 4'b1000;
	localparam [3:0] R_IDLE  = 4'b0001;
	localparam [3:0] R_WAIT  = 4'b0010;
	localparam [3:0] R_LAMP  = 4'b0100;
	localparam [3:0] R_PLAY  = 4'b1000;
	localparam [31:0] UNIT_SPAN = DELAY_UNIT_CYCLES - 1;
	localparam [23:0] UNIT_LAST = UNIT_SPAN[23:0];

	// Halves a density when the mode bit asks for it.
	function [7:0] dpi_of;
		input [7:0] full;
		input       half;
		begin
			dpi_of = half ? {1'b0, full[7:1]} : full;
		end
	endfunction

	function [1:0] params_of;
		input [7:0] cmd;
		begin
			if (cmd == `CMD_MACRO_RUN)
				params_of = 2'd3;
			else
				params_of = 2'd1;
		end
	endfunction

	// -----------------------------------------------------------------------
	// Registers
	// -----------------------------------------------------------------------
	reg [3:0]  pstate_reg;
	reg [3:0]  rstate_reg;
	reg [7:0]  cmd_reg;
	reg [1:0]  pcount_reg;
	reg [7:0]  arg0_reg;
	reg [7:0]  arg1_reg;
	reg        from_macro_reg;
	reg        selected_reg;
	reg        recording_reg;
	reg        prefix_stored_reg;
	reg [11:0] macro_len_reg;
	reg        abort_flag_reg;
	reg        image_def_reg;
	reg        charset_def_reg;
	reg [7:0]  width_reg;
	reg [7:0]  repeat_reg;
	reg [7:0]  units_reg;
	reg [7:0]  delay_reg;
	reg        feed_mode_reg;
	reg [23:0] tick_reg;
	reg [23:0] blink_reg;
	reg [10:0] play_addr_reg;
	reg        play_phase_reg;
	reg        feed_prev_reg;
	reg        bus_wr_reg;
	reg [7:0]  bus_addr_reg;

	wire [7:0] store_rd_data;
	wire       run_active = (rstate_reg != R_IDLE);
	wire       play_valid = (rstate_reg == R_PLAY) && play_phase_reg;
	wire       host_take  = rx_valid_i && rx_ready_o;
	wire       byte_valid = host_take || play_valid;
	wire [7:0] byte_data  = play_valid ? store_rd_data : rx_data_i;
	wire       feed_press = feed_switch_i && !feed_prev_reg;
	wire       last_param = (pstate_reg == P_PARAM) && (pcount_reg == 2'd1);
	wire       exec       = byte_valid && last_param;
	wire       store_en   = host_take && selected_reg && recording_reg &&
	                        (macro_len_reg < `MACRO_BYTES);
	wire       toggle_hit = host_take && selected_reg &&
	                        (pstate_reg == P_GS) &&
	                        (byte_data == `CMD_MACRO_TOGGLE);
	wire       run_hit    = exec && selected_reg && !from_macro_reg &&
	                        (cmd_reg == `CMD_MACRO_RUN);
	wire [1:0] img_mode   = byte_data[1:0];
	wire [10:0] img_limit = img_mode[0] ? (`LINE_DOTS >> 1)
	                                    : `LINE_DOTS;
	wire [10:0] img_width = {width_reg, 3'b000};

	assign rx_ready_o     = !run_active;
	assign busy_o         = run_active || print_busy_i;
	assign feed_advance_o = feed_switch_i &&
	                        !(run_active && feed_mode_reg);
	assign hreadyout_o    = 1'b1;
	assign hresp_o        = 1'b0;

	macro_store u_store
	(
		.clk_i     (clk_i),
		.wr_en_i   (store_en),
		.wr_addr_i (macro_len_reg[10:0]),
		.wr_data_i (byte_data),
		.rd_addr_i (play_addr_reg),
		.rd_data_o (store_rd_data)
	);

	// -----------------------------------------------------------------------
	// Command parser and actions
	// -----------------------------------------------------------------------
	always @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			pstate_reg     <= P_IDLE;
			cmd_reg        <= 8'h00;
			pcount_reg     <= 2'd0;
			arg0_reg       <= 8'h00;
			arg1_reg       <= 8'h00;
			from_macro_reg <= 1'b0;
			selected_reg   <= 1'b1;
			line_align_o   <= 2'b00;
			print_data_o   <= 8'h00;
			print_valid_o  <= 1'b0;
			image_print_o  <= 1'b0;
			image_mode_o   <= 2'b00;
			image_vdpi_o   <= `DPI_V_FULL;
			image_hdpi_o   <= `DPI_H_FULL;
			image_dots_o   <= 11'h000;
			full_cut_o     <= 1'b0;
			partial_cut_o  <= 1'b0;
			printer_init_o <= 1'b0;
		end
		else
		begin
			print_valid_o  <= 1'b0;
			image_print_o  <= 1'b0;
			full_cut_o     <= 1'b0;
			partial_cut_o  <= 1'b0;
			printer_init_o <= 1'b0;
			if (byte_valid)
			begin
				// Recorded bytes flow on to printing as usual.
				if (selected_reg)
				begin
					print_data_o  <= byte_data;
					print_valid_o <= 1'b1;
				end
				case (pstate_reg)
				P_IDLE:
				begin
					from_macro_reg <= play_valid;
					if (byte_data == `BYTE_ESC)
						pstate_reg <= P_ESC;
					else if (byte_data == `BYTE_GS)
						pstate_reg <= P_GS;
				end
				P_ESC:
				begin
					cmd_reg    <= byte_data;
					pcount_reg <= params_of(byte_data);
					pstate_reg <= P_IDLE;
					if (byte_data == `CMD_INPUT_SELECT ||
					    byte_data == `CMD_LINE_ALIGN)
						pstate_reg <= P_PARAM;
					else if (selected_reg && line_start_i &&
					         byte_data == `CMD_FULL_CUT)
						full_cut_o <= 1'b1;
					else if (selected_reg && line_start_i &&
					         byte_data == `CMD_PARTIAL_CUT)
						partial_cut_o <= 1'b1;
					else if (selected_reg &&
					         byte_data == `CMD_PRINTER_INIT)
					begin
						// Init leaves the macro store alone.
						printer_init_o <= 1'b1;
						selected_reg   <= 1'b1;
						line_align_o   <= 2'b00;
					end
				end
				P_GS:
				begin
					cmd_reg    <= byte_data;
					pcount_reg <= params_of(byte_data);
					if (byte_data == `CMD_PRINT_IMAGE ||
					    byte_data == `CMD_MACRO_RUN)
						pstate_reg <= P_PARAM;
					else
						pstate_reg <= P_IDLE;
				end
				P_PARAM:
				begin
					pcount_reg <= pcount_reg - 2'd1;
					if (pcount_reg == 2'd3)
						arg0_reg <= byte_data;
					if (pcount_reg == 2'd2)
						arg1_reg <= byte_data;
					if (last_param)
						pstate_reg <= P_IDLE;
					// Only input select is heard while deselected.
					if (last_param && cmd_reg == `CMD_INPUT_SELECT)
						selected_reg <= byte_data[0];
					if (last_param && selected_reg &&
					    cmd_reg == `CMD_LINE_ALIGN && line_start_i &&
					    byte_data <= 8'h02)
						line_align_o <= byte_data[1:0];
					if (last_param && selected_reg &&
					    cmd_reg == `CMD_PRINT_IMAGE &&
					    byte_data <= `IMAGE_MODE_MAX &&
					    print_buf_empty_i && image_def_reg)
					begin
						image_print_o <= 1'b1;
						image_mode_o  <= img_mode;
						image_hdpi_o  <= dpi_of(`DPI_H_FULL,
						                        img_mode[0]);
						image_vdpi_o  <= dpi_of(`DPI_V_FULL, img_mode[1]);
						image_dots_o  <= (img_width > img_limit) ?
						                 img_limit : img_width;
					end
				end
				default:
					pstate_reg <= P_IDLE;
				endcase
			end
		end
	end

	// -----------------------------------------------------------------------
	// Macro recording
	// -----------------------------------------------------------------------
	always @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			recording_reg     <= 1'b0;
			prefix_stored_reg <= 1'b0;
			macro_len_reg     <= 12'h000;
			macro_abort_o     <= 1'b0;
		end
		else
		begin
			macro_abort_o <= 1'b0;
			if (store_en)
			begin
				macro_len_reg     <= macro_len_reg + 12'h001;
				prefix_stored_reg <= (byte_data == `BYTE_GS);
			end
			if (run_hit && recording_reg)
			begin
				recording_reg <= 1'b0;
				macro_len_reg <= 12'h000;
				macro_abort_o <= 1'b1;
			end
			else if (toggle_hit)
			begin
				// The closing prefix byte was stored; take it back out.
				if (recording_reg && prefix_stored_reg)
					macro_len_reg <= macro_len_reg - 12'h001;
				else if (!recording_reg)
					macro_len_reg <= 12'h000;
				recording_reg <= !recording_reg;
			end
		end
	end

	// -----------------------------------------------------------------------
	// Macro execution
	// -----------------------------------------------------------------------
	always @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			rstate_reg     <= R_IDLE;
			repeat_reg     <= 8'h00;
			delay_reg      <= 8'h00;
			units_reg      <= 8'h00;
			feed_mode_reg  <= 1'b0;
			tick_reg       <= 24'h000000;
			blink_reg      <= 24'h000000;
			play_addr_reg  <= 11'h000;
			play_phase_reg <= 1'b0;
			feed_prev_reg  <= 1'b0;
			error_lamp_o   <= 1'b0;
		end
		else
		begin
			feed_prev_reg <= feed_switch_i;
			case (rstate_reg)
			R_IDLE:
			begin
				error_lamp_o <= 1'b0;
				if (run_hit && !recording_reg && macro_len_reg != 12'h000 &&
				    arg0_reg != 8'h00)
				begin
					repeat_reg    <= arg0_reg;
					delay_reg     <= arg1_reg;
					units_reg     <= arg1_reg;
					feed_mode_reg <= (byte_data == `RUN_MODE_FEED);
					tick_reg      <= 24'h000000;
					rstate_reg    <= R_WAIT;
				end
			end
			R_WAIT:
			begin
				if (units_reg == 8'h00)
				begin
					play_addr_reg  <= 11'h000;
					play_phase_reg <= 1'b0;
					blink_reg      <= 24'h000000;
					rstate_reg     <= feed_mode_reg ? R_LAMP : R_PLAY;
				end
				else if (tick_reg == UNIT_LAST)
				begin
					tick_reg  <= 24'h000000;
					units_reg <= units_reg - 8'h01;
				end
				else
					tick_reg <= tick_reg + 24'h000001;
			end
			R_LAMP:
			begin
				// Lamp flashes until the operator presses feed.
				if (blink_reg == `BLINK_CYCLES)
				begin
					blink_reg    <= 24'h000000;
					error_lamp_o <= !error_lamp_o;
				end
				else
					blink_reg <= blink_reg + 24'h000001;
				if (feed_press)
				begin
					error_lamp_o <= 1'b0;
					rstate_reg   <= R_PLAY;
				end
			end
			R_PLAY:
			begin
				play_phase_reg <= !play_phase_reg;
				if (play_phase_reg)
				begin
					play_addr_reg <= play_addr_reg + 11'h001;
					if ({1'b0, play_addr_reg} == macro_len_reg - 12'h001)
					begin
						repeat_reg <= repeat_reg - 8'h01;
						units_reg  <= delay_reg;
						tick_reg   <= 24'h000000;
						rstate_reg <= (repeat_reg == 8'h01) ?
						              R_IDLE : R_WAIT;
					end
				end
			end
			default:
				rstate_reg <= R_IDLE;
			endcase
		end
	end

	// -----------------------------------------------------------------------
	// AHB-Lite register slave
	// -----------------------------------------------------------------------
	wire addr_phase = hsel_i && hready_i && htrans_i[`HTRANS_NONSEQ_BIT];

	always @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			bus_wr_reg      <= 1'b0;
			bus_addr_reg    <= 8'h00;
			hrdata_o        <= 32'h00000000;
			image_def_reg   <= 1'b0;
			charset_def_reg <= 1'b0;
			width_reg       <= 8'h00;
			abort_flag_reg  <= 1'b0;
		end
		else
		begin
			bus_wr_reg   <= addr_phase && hwrite_i;
			bus_addr_reg <= haddr_i[7:0];
			if (printer_init_o)
				image_def_reg <= 1'b0;
			if (bus_wr_reg && bus_addr_reg == `REG_IMAGE_CTRL)
			begin
				width_reg <= hwdata_i[`F_WIDTH_HI:`F_WIDTH_LO];
				// Defining one kind of download clears the other.
				image_def_reg   <= hwdata_i[`F_IMAGE_DEF];
				charset_def_reg <= hwdata_i[`F_CHARSET_DEF] &&
				                   !hwdata_i[`F_IMAGE_DEF];
			end
			// A new abort beats a clear in the same cycle.
			if (bus_wr_reg && bus_addr_reg == `REG_STATUS_CLR &&
			    hwdata_i[`F_ABORT])
				abort_flag_reg <= 1'b0;
			if (macro_abort_o)
				abort_flag_reg <= 1'b1;
			hrdata_o <= 32'h00000000;
			if (addr_phase && !hwrite_i)
			begin
				if (haddr_i[7:0] == `REG_IMAGE_CTRL)
				begin
					hrdata_o[`F_IMAGE_DEF]   <= image_def_reg;
					hrdata_o[`F_CHARSET_DEF] <= charset_def_reg;
					hrdata_o[`F_WIDTH_HI:`F_WIDTH_LO] <= width_reg;
				end
				else if (haddr_i[7:0] == `REG_STATUS)
				begin
					hrdata_o[`F_SELECTED]  <= selected_reg;
					hrdata_o[`F_RECORDING] <= recording_reg;
					hrdata_o[`F_RUNNING]   <= run_active;
					hrdata_o[`F_ABORT]     <= abort_flag_reg;
					hrdata_o[`F_ALIGN_HI:`F_ALIGN_LO] <= line_align_o;
					hrdata_o[`F_LEN_HI:`F_LEN_LO]     <= macro_len_reg;
				end
			end
		end
	end

endmodule // printer_command_decoder

// ### verification/host_byte_source.sv
`timescale 1ns/1ps

module host_byte_source
(
	// Clock
	input  wire       clk_i,
	// Byte stream towards the printer
	input  wire       rx_ready_i,
	output reg  [7:0] rx_data_o,
	output reg        rx_valid_o
);
	integer stall_cnt;

	initial
	begin
		rx_data_o = 8'h00;
		rx_valid_o = 1'b0;
		stall_cnt = 0;
	end

	// A byte stays offered until an edge sees ready; a bound keeps a stuck
	// printer from hanging the host.
	task send(input [7:0] b);
		integer n;
		begin
			n = 0;
			rx_data_o <= b;
			rx_valid_o <= 1'b1;
			@(posedge clk_i);
			while (!rx_ready_i && n < 5000)
			begin
				n = n + 1;
				@(posedge clk_i);
			end
			if (n >= 5000)
				stall_cnt = stall_cnt + 1;
		end
	endtask

	// Released data lines show the inverse so stale values never match.
	task idle;
		begin
			rx_valid_o <= 1'b0;
			rx_data_o <= ~rx_data_o;
		end
	endtask
endmodule // host_byte_source

// ### verification/printer_command_decoder_chk.sv
`timescale 1ns/1ps

module printer_command_decoder_chk
(
	// Clock and reset
	input wire        clk_i,
	input wire        reset_n_i,
	// Host byte stream and print engine
	input wire [7:0]  rx_data_i,
	input wire        rx_valid_i,
	input wire        rx_ready_o,
	input wire        busy_o,
	input wire        line_start_i,
	input wire        print_buf_empty_i,
	input wire        print_busy_i,
	input wire [7:0]  print_data_o,
	input wire        print_valid_o,
	input wire        image_print_o,
	input wire [1:0]  image_mode_o,
	input wire [7:0]  image_vdpi_o,
	input wire [7:0]  image_hdpi_o,
	input wire [10:0] image_dots_o,
	input wire [1:0]  line_align_o,
	input wire        full_cut_o,
	input wire        partial_cut_o,
	input wire        printer_init_o,
	input wire        macro_abort_o,
	// Operator panel
	input wire        feed_switch_i,
	input wire        feed_advance_o
);
	wire take = rx_valid_i && rx_ready_o;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);

	full_cut_a: assert property (full_cut_o |-> $past(line_start_i) &&
		($past(!rx_ready_o) || $past(take && rx_data_i == 8'h69)))
		else $error("full cut without its trigger");
	part_cut_a: assert property (partial_cut_o |-> $past(line_start_i) &&
		($past(!rx_ready_o) || $past(take && rx_data_i == 8'h6D)))
		else $error("partial cut without its trigger");
	image_dens_a: assert property (image_print_o |->
		image_hdpi_o == (image_mode_o[0] ? 8'h4D : 8'h9A) &&
		image_vdpi_o == (image_mode_o[1] ? 8'h4E : 8'h9C))
		else $error("image density wrong for mode");
	image_clip_a: assert property (image_print_o |->
		image_dots_o <= (image_mode_o[0] ? 11'h120 : 11'h240))
		else $error("image wider than one line");
	image_buf_a: assert property (image_print_o |-> $past(print_buf_empty_i))
		else $error("image printed over pending data");
	align_set_a: assert property ($changed(line_align_o) |->
		(printer_init_o || $past(line_start_i)) && line_align_o != 2'h3)
		else $error("alignment changed off line start");
	busy_eng_a: assert property (print_busy_i |-> busy_o)
		else $error("busy missing while engine busy");
	feed_pass_a: assert property (!busy_o |-> feed_advance_o == feed_switch_i)
		else $error("feed advance blocked while idle");
	run_hold_a: assert property (!rx_ready_o |-> busy_o)
		else $error("input stalled without a run");
	echo_byte_a: assert property (print_valid_o && $past(rx_ready_o) |->
		$past(take) && print_data_o == $past(rx_data_i))
		else $error("passed byte differs from taken byte");
	abort_cause_a: assert property (macro_abort_o |-> $past(take))
		else $error("abort without a received byte");
endmodule // printer_command_decoder_chk

bind printer_command_decoder printer_command_decoder_chk i_chk (.*);

// ### verification/printer_command_decoder_test.sv
`timescale 1ns/1ps

`define CHK(n, e, a) \
	begin \
		tests_run = tests_run + 1; \
		if ((a) !== (e)) \
		begin \
			error_cnt = error_cnt + 1; \
			$display("[FAIL] %s exp %0h got %0h", n, e, a); \
		end \
	end

module printer_command_decoder_test;
	reg         clk_i, reset_n_i, hsel, hwrite, line_start, buf_empty;
	reg         pbusy, feed;
	reg  [31:0] haddr, hwdata, r;
	reg  [1:0]  htrans;
	wire [31:0] hrdata;
	wire        hready, hresp, rx_ready, rx_valid, busy, pv, img, fc, pc;
	wire        init, ab, feed_adv, lamp;
	wire [7:0]  rx_data, pdata, vdpi, hdpi;
	wire [1:0]  mode, align;
	wire [10:0] dots;
	integer     error_cnt, tests_run, seed, i, k, w;
	integer     pv_n, img_n, fc_n, pc_n, init_n, ab_n;

	printer_command_decoder #(.DELAY_UNIT_CYCLES(10)) i_printer_command_decoder
	(
		.clk_i(clk_i), .reset_n_i(reset_n_i), .hsel_i(hsel),
		.haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
		.hsize_i(3'b010), .hwdata_i(hwdata), .hready_i(hready),
		.hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
		.rx_data_i(rx_data), .rx_valid_i(rx_valid), .rx_ready_o(rx_ready),
		.busy_o(busy), .line_start_i(line_start),
		.print_buf_empty_i(buf_empty), .print_busy_i(pbusy),
		.print_data_o(pdata), .print_valid_o(pv), .image_print_o(img),
		.image_mode_o(mode), .image_vdpi_o(vdpi), .image_hdpi_o(hdpi),
		.image_dots_o(dots), .line_align_o(align), .full_cut_o(fc),
		.partial_cut_o(pc), .printer_init_o(init), .macro_abort_o(ab),
		.feed_switch_i(feed), .feed_advance_o(feed_adv),
		.error_lamp_o(lamp)
	);

	host_byte_source i_host_byte_source
	(
		.clk_i(clk_i), .rx_ready_i(rx_ready), .rx_data_o(rx_data),
		.rx_valid_o(rx_valid)
	);

	initial
	begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end

	// Counting only out of reset keeps unknown outputs at time zero from
	// poisoning the pulse counters.
	always @(negedge clk_i)
	begin
		if (reset_n_i === 1'b1)
		begin
			pv_n = pv_n + pv;
			img_n = img_n + img;
			fc_n = fc_n + fc;
			pc_n = pc_n + pc;
			init_n = init_n + init;
			ab_n = ab_n + ab;
		end
	end

	function [10:0] exp_dots(input [7:0] wd, input [1:0] m);
		reg [10:0] lim;
		begin
			lim = m[0] ? 11'h120 : 11'h240;
			exp_dots = ({wd, 3'b000} > lim) ? lim : {wd, 3'b000};
		end
	endfunction

	task stop_test;
		begin
			error_cnt = error_cnt + i_host_byte_source.stall_cnt;
			$display("errors %0d checks %0d", error_cnt, tests_run);
			if (error_cnt == 0 && tests_run > 0)
				$display("All tests passed");
			else
				$display("Some tests failed");
			$finish;
		end
	endtask

	task cyc(input integer n);
		repeat (n) @(posedge clk_i);
	endtask

	task ahb(input wr, input [31:0] a, input [31:0] d);
		begin
			hsel <= 1'b1;
			hwrite <= wr;
			haddr <= a;
			htrans <= 2'b10;
			waith;
			hsel <= 1'b0;
			htrans <= 2'b00;
			hwdata <= d;
			waith;
			r = hrdata;
		end
	endtask

	task waith;
		integer n;
		begin
			n = 0;
			@(posedge clk_i);
			while (!hready && n < 100)
			begin
				n = n + 1;
				@(posedge clk_i);
			end
			if (n >= 100)
			begin
				error_cnt = error_cnt + 1;
				stop_test;
			end
		end
	endtask

	task waitb(input v);
		integer n;
		begin
			n = 0;
			while (busy !== v && n < 2000)
			begin
				n = n + 1;
				@(posedge clk_i);
			end
			if (n >= 2000)
			begin
				error_cnt = error_cnt + 1;
				stop_test;
			end
			cyc(3);
		end
	endtask

	task snd(input [39:0] v, input integer n);
		integer j;
		begin
			for (j = n - 1; j >= 0; j = j - 1)
				i_host_byte_source.send(v[8 * j +: 8]);
			i_host_byte_source.idle;
			cyc(3);
		end
	endtask

	initial
	begin
		{reset_n_i, hsel, hwrite, pbusy, feed, haddr, hwdata, htrans} = 0;
		{line_start, buf_empty} = 2'b11;
		{error_cnt, tests_run, pv_n, img_n, fc_n, pc_n, init_n, ab_n} = 0;
		seed = 32'hebbda556;
		cyc(12);
		reset_n_i <= 1'b1;
		cyc(1);
		ahb(0, 32'h04, 0);
		`CHK("status", 32'h1, r)
		`CHK("align", 2'h0, align)
		`CHK("hresp", 1'b0, hresp)
		ahb(1, 32'h40, 32'hFFFFFFFF);
		ahb(0, 32'h40, 0);
		`CHK("unmapped", 32'h0, r)
		ahb(1, 32'h00, 32'h3);
		ahb(0, 32'h00, 0);
		`CHK("ctrl", 2'h1, r[1:0])
		for (i = 0; i < 8; i = i + 1)
		begin
			w = (i < 4) ? 8'hFF : (($random(seed) & 8'hFF) | 1);
			ahb(1, 32'h00, {16'h0, w[7:0], 8'h01});
			k = img_n;
			snd({8'h1D, 8'h2F, 6'h0, i[1:0]}, 3);
			`CHK("image", k + 1, img_n)
			`CHK("mode", i[1:0], mode)
			`CHK("hdpi", i[0] ? 8'h4D : 8'h9A, hdpi)
			`CHK("vdpi", i[1] ? 8'h4E : 8'h9C, vdpi)
			`CHK("dots", exp_dots(w[7:0], i[1:0]), dots)
		end
		k = img_n;
		snd(24'h1D2F04, 3);
		`CHK("image mode", k, img_n)
		buf_empty <= 1'b0;
		k = img_n;
		snd(24'h1D2F00, 3);
		`CHK("image busy", k, img_n)
		buf_empty <= 1'b1;
		ahb(1, 32'h00, 0);
		snd(24'h1D2F00, 3);
		`CHK("image none", k, img_n)
		for (i = 0; i < 4; i = i + 1)
		begin
			line_start <= i[0];
			k = fc_n;
			w = pc_n;
			snd(16'h1B69, 2);
			snd(16'h1B6D, 2);
			`CHK("full cut", k + i[0], fc_n)
			`CHK("part cut", w + i[0], pc_n)
		end
		w = 0;
		for (i = 0; i < 8; i = i + 1)
		begin
			line_start <= (i < 4);
			snd({8'h1B, 8'h61, 6'h0, i[1:0]}, 3);
			if (i < 3)
				w = i;
			`CHK("align", w[1:0], align)
		end
		line_start <= 1'b1;
		snd(24'h1B3DFE, 3);
		k = pv_n;
		w = fc_n;
		snd(24'h411B69, 3);
		`CHK("deselected pass", k, pv_n)
		`CHK("deselected cut", w, fc_n)
		pbusy <= 1'b1;
		cyc(1);
		`CHK("busy", 1'b1, busy)
		pbusy <= 1'b0;
		ahb(0, 32'h04, 0);
		`CHK("selected", 1'b0, r[0])
		snd(24'h1B3D01, 3);
		ahb(0, 32'h04, 0);
		`CHK("selected", 1'b1, r[0])
		snd(16'h1D3A, 2);
		for (i = 0; i < 2050; i = i + 1)
			i_host_byte_source.send(8'h20 + ($random(seed) & 8'h3F));
		snd(16'h1D3A, 2);
		ahb(0, 32'h04, 0);
		`CHK("macro full", 12'h800, r[27:16])
		k = pv_n;
		snd(40'h1D3A414243, 5);
		snd(16'h1D3A, 2);
		`CHK("record echo", k + 7, pv_n)
		ahb(0, 32'h04, 0);
		`CHK("macro len", 12'h3, r[27:16])
		k = init_n;
		snd(16'h1B40, 2);
		ahb(0, 32'h04, 0);
		`CHK("init", k + 1, init_n)
		`CHK("kept len", 12'h3, r[27:16])
		k = pv_n;
		snd(40'h1D5E020100, 5);
		waitb(0);
		`CHK("run twice", k + 11, pv_n)
		k = pv_n;
		snd(40'h1D5E000100, 5);
		cyc(30);
		`CHK("zero count", k + 5, pv_n)
		k = pv_n;
		snd(40'h1D5E010001, 5);
		cyc(20);
		`CHK("await feed", 1'b1, busy)
		`CHK("stall", 1'b0, rx_ready)
		feed <= 1'b1;
		#10;
		`CHK("feed adv", 1'b0, feed_adv)
		waitb(0);
		feed <= 1'b0;
		`CHK("feed run", k + 8, pv_n)
		`CHK("lamp off", 1'b0, lamp)
		k = ab_n;
		snd(24'h1D3A51, 3);
		snd(40'h1D5E010000, 5);
		ahb(0, 32'h04, 0);
		`CHK("abort", k + 1, ab_n)
		`CHK("abort flag", 1'b1, r[3])
		`CHK("erased", 12'h0, r[27:16])
		ahb(1, 32'h08, 32'h8);
		ahb(0, 32'h04, 0);
		`CHK("abort clr", 1'b0, r[3])
		k = pv_n;
		snd(40'h1D5E010000, 5);
		cyc(30);
		`CHK("empty run", k + 5, pv_n)
		snd(24'h1B3D00, 3);
		reset_n_i <= 1'b0;
		cyc(2);
		reset_n_i <= 1'b1;
		cyc(1);
		ahb(0, 32'h04, 0);
		`CHK("reset status", 32'h1, r)
		stop_test;
	end
endmodule // printer_command_decoder_test
